// ===== rtl/arh_pkg.sv
/*
  package for the converter read/start host port: pin timing counts,
  mode encodings and state codes.
  assumes a 100 MHz core clock; the bench overrides the host gap and conversion counts.
*/
package arh_pkg;
  // core clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // conversion time, ns, and least gap between reads in pipelined mode
  localparam int CONV_TIME_NS = 2000;
  localparam int READ_GAP_NS = 2500;
  // least times round up to whole cycles
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES =
    (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // wait mode gives up after this many cycles with no ready
  localparam int TIMEOUT_CYCLES = 1000;
  // strobe timer load in pipelined mode, cycles; the strobe stays low one cycle more
  localparam int STROBE_CYCLES = 4;
  localparam int CNT_W = 12;
  localparam int CHAN_W = 3;
  localparam int DATA_W = 8;

  // mode select values
  localparam logic MODE_WAIT = 1'h0;
  localparam logic MODE_PIPE = 1'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_RELEASE = 5'h08,
    ST_GAP = 5'h10
  } arh_state_t;
endpackage

// ===== rtl/arh_gap_timer.sv
/*
  down counter used for strobe hold, timeout and read spacing.
  assumes load and count are synchronous to core_clk.
*/
`timescale 1ns/1ps
module arh_gap_timer #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } arh_tmr_t;
  arh_tmr_t s_q;
  arh_tmr_t s_d;

  // load wins over counting
  always_comb
  begin
    s_d = s_q;
    if (load)
      s_d.cnt = load_val;
    else if (s_q.cnt != '0)
      s_d.cnt = s_q.cnt - W'(1);
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign zero = (s_q.cnt == '0);
endmodule

// ===== rtl/arh_host.sv
/*
  host controller for a clockless multichannel 8-bit converter that sits
  on the bus as read-only memory. one user request performs one read
  cycle: wait mode stretches it until ready or timeout, pipelined mode returns the
  previous result and spaces reads by the least gap.
  assumes the converter pins are synchronous to core_clk (externally
  registered) and that its ready line has a pull-up on the board.

  // Summary of operation
  // - both strobes low start a conversion
  // - wait mode: channel bits steady while strobed
  // - wait mode: host stretches read using ready
  // - pipelined: ready line tied low, ignored
  // - pipelined: reads spaced at least 2.5 us
  // - host reaches converter as read-only memory
*/
`timescale 1ns/1ps
module arh_host #(
  parameter int CONV_CYC = arh_pkg::CONV_CYCLES,
  parameter int GAP_CYC = arh_pkg::GAP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // user request
  input wire logic req_valid,
  input wire logic [arh_pkg::CHAN_W-1:0] req_chan,
  input wire logic req_mode,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [arh_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  // converter pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic [arh_pkg::CHAN_W-1:0] channel_sel_bits,
  input wire logic [arh_pkg::DATA_W-1:0] result_bus,
  input wire logic conversion_wait_n,
  input wire logic conversion_done_n
);
  typedef struct packed {
    arh_pkg::arh_state_t st;
    logic mode;
    logic cs_n;
    logic rd_n;
    logic [arh_pkg::CHAN_W-1:0] chan;
    logic rdy;
    logic vld;
    logic tmo;
    logic [arh_pkg::DATA_W-1:0] data;
    // strobe run lengths, watched by the bound checks
    logic [arh_pkg::CNT_W-1:0] lo_cnt;
    logic [arh_pkg::CNT_W-1:0] hi_cnt;
  } arh_host_t;
  arh_host_t s_q;
  arh_host_t s_d;
  logic tmr_load;
  logic [arh_pkg::CNT_W-1:0] tmr_val;
  logic tmr_zero;
  logic ready_seen;

  // shared timer: strobe hold, timeout and read spacing
  arh_gap_timer #(
    .W(arh_pkg::CNT_W)
  ) u_tmr (
    .core_clk(core_clk),
    .reset(reset),
    .load(tmr_load),
    .load_val(tmr_val),
    .zero(tmr_zero)
  );

  // either status pin ends the wait; ready rise or done fall
  assign ready_seen = conversion_wait_n || !conversion_done_n;

  always_comb
  begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    s_d.vld = 1'b0;
    // a wait read parks the high count at its ceiling, so only
    // pipelined reads are held to the gap afterwards
    if (s_q.cs_n)
    begin
      s_d.lo_cnt = '0;
      if (s_q.hi_cnt != '1)
        s_d.hi_cnt = s_q.hi_cnt + arh_pkg::CNT_W'(1);
    end
    else
    begin
      s_d.lo_cnt = s_q.lo_cnt + arh_pkg::CNT_W'(1);
      if (s_q.mode == arh_pkg::MODE_PIPE)
        s_d.hi_cnt = '0;
      else
        s_d.hi_cnt = '1;
    end
    unique case (s_q.st)
      arh_pkg::ST_IDLE:
      begin
        s_d.rdy = 1'b1;
        if (req_valid && s_q.rdy)
        begin
          s_d.rdy = 1'b0;
          s_d.tmo = 1'b0;
          s_d.mode = req_mode;
          s_d.chan = req_chan;
          s_d.st = arh_pkg::ST_SETUP;
        end
      end
      // address settles one cycle before the strobes fall
      arh_pkg::ST_SETUP:
      begin
        s_d.cs_n = 1'b0;
        s_d.rd_n = 1'b0;
        tmr_load = 1'b1;
        if (s_q.mode == arh_pkg::MODE_WAIT)
          tmr_val = arh_pkg::CNT_W'(arh_pkg::TIMEOUT_CYCLES);
        else
          tmr_val = arh_pkg::CNT_W'(arh_pkg::STROBE_CYCLES);
        s_d.st = arh_pkg::ST_STROBE;
      end
      // channel bits never change here; they move only in idle
      arh_pkg::ST_STROBE:
      begin
        if (s_q.mode == arh_pkg::MODE_WAIT)
        begin
          // ready pin only means anything in wait mode
          if (ready_seen)
          begin
            s_d.data = result_bus;
            s_d.vld = 1'b1;
            s_d.cs_n = 1'b1;
            s_d.rd_n = 1'b1;
            s_d.st = arh_pkg::ST_RELEASE;
          end
          else if (tmr_zero)
          begin
            s_d.tmo = 1'b1;
            s_d.vld = 1'b1;
            s_d.cs_n = 1'b1;
            s_d.rd_n = 1'b1;
            s_d.st = arh_pkg::ST_RELEASE;
          end
        end
        else if (tmr_zero)
        begin
          // previous result, read strobe rise latches the address
          s_d.data = result_bus;
          s_d.vld = 1'b1;
          s_d.cs_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.st = arh_pkg::ST_RELEASE;
        end
      end
      // pipelined reads wait out the conversion plus recovery
      arh_pkg::ST_RELEASE:
      begin
        tmr_load = 1'b1;
        if (s_q.mode == arh_pkg::MODE_PIPE)
          tmr_val = arh_pkg::CNT_W'(GAP_CYC);
        else
          tmr_val = arh_pkg::CNT_W'(1);
        s_d.st = arh_pkg::ST_GAP;
      end
      arh_pkg::ST_GAP:
      begin
        if (tmr_zero)
        begin
          s_d.rdy = 1'b1;
          s_d.st = arh_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = arh_pkg::ST_IDLE;
        s_d.cs_n = 1'b1;
        s_d.rd_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q.st <= arh_pkg::ST_IDLE;
      s_q.mode <= arh_pkg::MODE_WAIT;
      s_q.cs_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.chan <= '0;
      s_q.rdy <= 1'b0;
      s_q.vld <= 1'b0;
      s_q.tmo <= 1'b0;
      s_q.data <= '0;
      s_q.lo_cnt <= '0;
      s_q.hi_cnt <= '1;
    end
    else
      s_q <= s_d;
  end

  // all outputs straight from the state register
  assign req_ready = s_q.rdy;
  assign rsp_valid = s_q.vld;
  assign rsp_data = s_q.data;
  assign rsp_timeout = s_q.tmo;
  assign chip_select_n = s_q.cs_n;
  assign read_strobe_n = s_q.rd_n;
  assign channel_sel_bits = s_q.chan;

  // both strobes always move together
  chk_strobes_paired: assert property (
    @(posedge core_clk) disable iff (reset)
    chip_select_n == read_strobe_n)
    else $error("select and read strobes differ");

  // channel bits steady across a strobed read
  chk_chan_stable: assert property (
    @(posedge core_clk) disable iff (reset)
    !chip_select_n && !$past(chip_select_n) |->
    $stable(channel_sel_bits))
    else $error("channel bits moved during read");

  // pipelined strobe low for the fixed count
  chk_pipe_strobe: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(chip_select_n) && s_q.mode == arh_pkg::MODE_PIPE |->
    !chip_select_n [*5] ##1 chip_select_n)
    else $error("pipelined strobe width wrong");

  // strobes stay high until the gap is counted out after a pipelined
  // read; a counter stands in for a long repetition
  chk_pipe_gap: assert property (
    @(posedge core_clk) disable iff (reset)
    chip_select_n && s_q.hi_cnt < arh_pkg::CNT_W'(GAP_CYC) |=>
    chip_select_n)
    else $error("pipelined reads too close");

  // wait read ends one cycle after ready
  chk_wait_end: assert property (
    @(posedge core_clk) disable iff (reset)
    s_q.st == arh_pkg::ST_STROBE && s_q.mode == arh_pkg::MODE_WAIT &&
    ready_seen |=> chip_select_n && rsp_valid && !rsp_timeout)
    else $error("wait read not ended on ready");

  // captured data is what the bus showed
  chk_data_cap: assert property (
    @(posedge core_clk) disable iff (reset)
    rsp_valid && !rsp_timeout |-> rsp_data == $past(result_bus))
    else $error("returned data not bus value");

  // strobe low run never outlasts the timeout count
  chk_wait_bound: assert property (
    @(posedge core_clk) disable iff (reset)
    !chip_select_n |->
    s_q.lo_cnt <= arh_pkg::CNT_W'(arh_pkg::TIMEOUT_CYCLES))
    else $error("read strobe never released");

  // answer comes in the same cycle as a strobe release
  chk_rsp_cause: assert property (
    @(posedge core_clk) disable iff (reset)
    rsp_valid |-> $rose(chip_select_n))
    else $error("answer without a read");
endmodule

// ===== verification/arh_conv_model.sv
/*
  behavioural model of the clockless 8-channel converter pins.
  assumes pins are sampled on core_clk; stall freezes a conversion.
*/
`timescale 1ns/1ps
module arh_conv_model #(
  parameter int CONV = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // scenario control
  input wire logic mode,
  input wire logic stall,
  // converter pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [2:0] channel_sel_bits,
  output logic [7:0] result_bus,
  output logic conversion_wait_n,
  output logic conversion_done_n
);
  logic strb, strb_q, fin_q;
  logic [2:0] chan_q;
  logic [7:0] res_q, float_q;
  int cnt_q;
  // both strobes low is a read
  assign strb = !chip_select_n && !read_strobe_n;
  // pulled up once released; tied low in pipelined mode
  assign conversion_wait_n = mode ? 1'b0 : !(strb && !fin_q);
  assign conversion_done_n = !fin_q;
  // floating bus shows a changing pattern, not a stale value
  assign result_bus = (strb && (mode || fin_q)) ? res_q :
    float_q;
  // conversion timer and result latch
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      strb_q <= 1'b0;
      fin_q <= 1'b0;
      cnt_q <= 0;
      chan_q <= 3'h0;
      res_q <= 8'h00;
      float_q <= 8'h5a;
    end
    else
    begin
      strb_q <= strb;
      float_q <= float_q + 8'h3b;
      if (strb && !strb_q)
      begin
        cnt_q <= CONV;
        // pipelined done stays low until this read ends
        if (!mode) fin_q <= 1'b0;
        if (!mode) chan_q <= channel_sel_bits;
      end
      else if (cnt_q > 1 && !stall) cnt_q <= cnt_q - 1;
      else if (cnt_q == 1 && !stall)
      begin
        cnt_q <= 0;
        fin_q <= 1'b1;
        res_q <= {5'h00, chan_q} * 8'h11 + 8'h07;
      end
      if (!strb && strb_q)
      begin
        fin_q <= 1'b0;
        if (mode) chan_q <= channel_sel_bits;
      end
    end
  end
endmodule

// ===== verification/adc_read_start_host_port_tb_top.sv
/*
  self-checking bench for the converter host port.
  assumes the converter model sits on the pins; short counts used.
*/
`timescale 1ns/1ps
module adc_read_start_host_port_tb_top;
  logic core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_mode = 1'b0;
  logic [2:0] req_chan = 3'h0;
  logic req_ready, rsp_valid, rsp_timeout, chip_select_n, read_strobe_n;
  logic [2:0] channel_sel_bits;
  logic [7:0] rsp_data, result_bus, d;
  logic conversion_wait_n, conversion_done_n, t, stall = 1'b0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  // short conversion and gap keep the run brief
  arh_host #(.CONV_CYC(10), .GAP_CYC(8)) arh_host_i (.core_clk(core_clk),
    .reset(reset), .req_valid(req_valid), .req_chan(req_chan),
    .req_mode(req_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .channel_sel_bits(channel_sel_bits), .result_bus(result_bus),
    .conversion_wait_n(conversion_wait_n),
    .conversion_done_n(conversion_done_n));
  arh_conv_model #(.CONV(10)) arh_conv_model_i (.core_clk(core_clk),
    .reset(reset), .mode(req_mode), .stall(stall),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .channel_sel_bits(channel_sel_bits), .result_bus(result_bus),
    .conversion_wait_n(conversion_wait_n),
    .conversion_done_n(conversion_done_n));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (exp !== got)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one read cycle; pins watched while the strobes are low
  task do_read(input logic m, input logic [2:0] ch);
    logic r;
    int n;
    req_mode = m;
    req_chan = ch;
    req_valid = 1'b1;
    r = 1'b0;
    n = 0;
    while (r !== 1'b1 && n < 600)
    begin
      r = req_ready;
      @(posedge core_clk);
      #1;
      n++;
    end
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1100)
    begin
      if (chip_select_n === 1'b0)
      begin
        chk("chan pins", {5'h00, ch}, {5'h00, channel_sel_bits});
        chk("rd strobe", 8'h00, {7'h00, read_strobe_n});
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    d = rsp_data;
    t = rsp_timeout;
    chk("answer", 8'h01, {7'h00, rsp_valid});
  endtask
  task t_wait;
    for (int c = 0; c < 8; c++)
    begin
      do_read(1'b0, c[2:0]);
      chk("wait data", 8'h11 * c[7:0] + 8'h07, d);
      chk("wait timeout", 8'h00, {7'h00, t});
    end
    $display("test wait mode done");
  endtask
  // conversion held back: host must give up, then recover
  task t_timeout;
    stall = 1'b1;
    do_read(1'b0, 3'h3);
    chk("timeout flag", 8'h01, {7'h00, t});
    stall = 1'b0;
    do_read(1'b0, 3'h6);
    chk("after timeout", 8'h6d, d);
    $display("test timeout done");
  endtask
  // each read returns the channel of the read before
  task t_pipe;
    logic [7:0] e;
    for (int i = 0; i < 5; i++)
    begin
      do_read(1'b1, 3'(2 + 3 * i));
      e = 8'h11 * 8'((3 * i - 1) % 8) + 8'h07;
      if (i > 0) chk("pipe data", e, d);
      repeat (12) @(posedge core_clk);
      #1;
      chk("done low", 8'h00, {7'h00, conversion_done_n});
    end
    $display("test pipelined mode done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("watchdog expired");
      wrap_up;
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_wait;
    t_timeout;
    t_pipe;
    wrap_up;
  end
endmodule
